// ### hw/cmp_ctrl_pkg.sv
// package: register map, fields and reset values of the comparator control block
// Function
// - bit 7 reads the second comparator result, high when plus exceeds minus, reversed when its invert bit is set.
// - bit 6 reads the first comparator result the same way under its own invert bit.
// - bit 5 is a writable control that inverts the second comparator output.
// - bit 4 is a writable control that inverts the first comparator output.
// - in mode 110 the input switch bit picks pins 3 and 2 as inverting inputs when set, pins 0 and 1 when clear.
// - bits 2 to 0 are a writable mode field: 000 and 111 turn both comparators off, 110 uses the reference, the other five share one pin pairing.
// - comparator inputs come from port A pins 0 to 3 and outputs may drive port A pins 4 and 5 per mode.
// - the port A direction bits enable the output drivers of the comparator pins 4 and 5 only in mode 101.
// - the internal reference voltage can be chosen as a comparator input.
// - the change flag is set whenever either result changes, whether or not the interrupt is enabled.
// - any read or write of the control register ends the mismatch, which until then keeps setting the flag.
// - in mode 110 the internal reference feeds the non-inverting input of both comparators.
// - reset returns the control register to its reset state with mode field 111, comparators off.
package cmp_ctrl_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h9c;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'ha0;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'ha4;
  localparam int RESULT2_BIT = 7;
  localparam int RESULT1_BIT = 6;
  localparam int INVERT2_BIT = 5;
  localparam int INVERT1_BIT = 4;
  localparam int INSWITCH_BIT = 3;
  localparam logic [5:0] CTRL_RESET = 6'h07;
  localparam logic [2:0] MODE_REF = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam logic [2:0] MODE_OUT = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/cmp_route.sv
// module: input and output routing of one comparator per mode
`timescale 1ns/1ps
module cmp_route (
  // configuration
  input wire logic [2:0] mode,
  input wire logic inSwitch,
  input wire logic second,
  // analog side levels, as raw comparator outcomes for each pairing
  input wire logic [3:0] pinAboveRef,
  input wire logic [3:0] pinAbovePin,
  // result
  output logic enabled,
  output logic rawOut
);
  // selection of comparator pairing from mode
  always_comb begin
    enabled = 1'b1;
    rawOut = 1'b0;
    unique case (mode)
      cmp_ctrl_pkg::MODE_OFF: enabled = 1'b0;
      // reference on plus, minus chosen by switch
      cmp_ctrl_pkg::MODE_REF: rawOut = inSwitch ? pinAboveRef[second ? 2 : 3] : pinAboveRef[second ? 1 : 0];
      3'h0: enabled = 1'b0; // comparators off, output low
      default: rawOut = second ? pinAbovePin[1] : pinAbovePin[0];
    endcase
  end
endmodule

// ### hw/dual_comparator_control.sv
// module: comparator control register, results, change flag and axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dual_comparator_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog front end outcomes, synchronous
  input wire logic [3:0] pinAboveRef,
  input wire logic [3:0] pinAbovePin,
  // port a direction, low bit means output
  input wire logic [5:4] portADirection,
  // port a pins 4 and 5 output side
  output logic [5:4] portAPinOut,
  output logic [5:4] portAPinOe,
  // reference enable and interrupt
  output logic refSelect,
  output logic irq
);
  logic [5:0] ctrl_q;
  logic [1:0] result_q;
  logic [1:0] latched_q;
  logic changeFlag_q;
  logic mask_q;
  logic [1:0] raw;
  logic [1:0] en;
  logic [1:0] result;
  logic awHeld_q, wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite, doRead, ctrlAccess;

  // per comparator routing
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    cmp_route u_route (
      .mode(ctrl_q[2:0]),
      .inSwitch(ctrl_q[cmp_ctrl_pkg::INSWITCH_BIT]),
      .second(i == 1),
      .pinAboveRef(pinAboveRef),
      .pinAbovePin(pinAbovePin),
      .enabled(en[i]),
      .rawOut(raw[i])
    );
  end

  // polarity applied to both results
  assign result[0] = en[0] & (raw[0] ^ ctrl_q[cmp_ctrl_pkg::INVERT1_BIT]);
  assign result[1] = en[1] & (raw[1] ^ ctrl_q[cmp_ctrl_pkg::INVERT2_BIT]);
  assign refSelect = ctrl_q[2:0] == cmp_ctrl_pkg::MODE_REF;

  // live results registered
  always_ff @(posedge core_clk) begin
    if (reset) result_q <= 2'h0;
    else result_q <= result;
  end

  // pin outputs in output mode, enable follows direction bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      portAPinOut <= 2'h0;
      portAPinOe <= 2'h0;
    end else begin
      portAPinOut <= result_q;
      portAPinOe <= (ctrl_q[2:0] == cmp_ctrl_pkg::MODE_OUT) ? ~portADirection : 2'h0;
    end
  end

  // write channel capture
  assign s_axi_awready = !awHeld_q;
  assign s_axi_wready = !wHeld_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  // write response
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cmp_ctrl_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_q[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2] ||
        awAddr_q[7:2] == cmp_ctrl_pkg::IRQ_MASK_OFFSET[7:2] ||
        awAddr_q[7:2] == cmp_ctrl_pkg::IRQ_STATUS_OFFSET[7:2]) ? cmp_ctrl_pkg::RESP_OKAY : cmp_ctrl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register, result bits not writable
  always_ff @(posedge core_clk) begin
    if (reset) ctrl_q <= cmp_ctrl_pkg::CTRL_RESET;
    else if (doWrite && wStrb_q[0] && awAddr_q[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2])
      ctrl_q <= wData_q[5:0];
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (reset) mask_q <= 1'b0;
    else if (doWrite && wStrb_q[0] && awAddr_q[7:2] == cmp_ctrl_pkg::IRQ_MASK_OFFSET[7:2])
      mask_q <= wData_q[0];
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cmp_ctrl_pkg::RESP_OKAY;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cmp_ctrl_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2])
        s_axi_rdata <= {24'h0, result_q, ctrl_q};
      else if (s_axi_araddr[7:2] == cmp_ctrl_pkg::IRQ_STATUS_OFFSET[7:2])
        s_axi_rdata <= {31'h0, changeFlag_q};
      else if (s_axi_araddr[7:2] == cmp_ctrl_pkg::IRQ_MASK_OFFSET[7:2])
        s_axi_rdata <= {31'h0, mask_q};
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= cmp_ctrl_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // any control register access ends mismatch by relatching results
  assign ctrlAccess = (doRead && s_axi_araddr[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2]) ||
    (doWrite && awAddr_q[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2]);
  always_ff @(posedge core_clk) begin
    if (reset) latched_q <= 2'h0;
    else if (ctrlAccess) latched_q <= result_q;
  end

  // sticky change flag, cleared by status read, mismatch wins
  always_ff @(posedge core_clk) begin
    if (reset) changeFlag_q <= 1'b0;
    else if (result_q != latched_q) changeFlag_q <= 1'b1;
    else if (doRead && s_axi_araddr[7:2] == cmp_ctrl_pkg::IRQ_STATUS_OFFSET[7:2]) changeFlag_q <= 1'b0;
  end
  assign irq = changeFlag_q & mask_q;

  // checks
  // only the edge just after release is checked, so the first edge of the run never looks back past time zero
  reset_mode_a: assert property (@(posedge core_clk) !reset && $past(reset) |->
    ctrl_q[2:0] == cmp_ctrl_pkg::MODE_OFF) else $error("mode not off after reset");
  flag_set_a: assert property (@(posedge core_clk) disable iff (reset) result_q != latched_q |=> changeFlag_q)
    else $error("change flag not set on mismatch");
  access_ends_a: assert property (@(posedge core_clk) disable iff (reset) ctrlAccess |=> latched_q == $past(result_q))
    else $error("access did not end mismatch");
  result_ro_a: assert property (@(posedge core_clk) disable iff (reset)
    doWrite |=> result_q == $past(result)) else $error("write disturbed result");
  pol_one_a: assert property (@(posedge core_clk) disable iff (reset)
    en[0] |-> result[0] == (raw[0] ^ ctrl_q[cmp_ctrl_pkg::INVERT1_BIT])) else $error("first polarity wrong");
  pol_two_a: assert property (@(posedge core_clk) disable iff (reset)
    en[1] |-> result[1] == (raw[1] ^ ctrl_q[cmp_ctrl_pkg::INVERT2_BIT])) else $error("second polarity wrong");
  dir_gate_a: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> (portAPinOe & $past(portADirection)) == 2'h0) else $error("driving an input pin");
  ref_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    refSelect |-> ctrl_q[2:0] == cmp_ctrl_pkg::MODE_REF) else $error("reference outside mode 110");
  mode_write_a: assert property (@(posedge core_clk) disable iff (reset)
    doWrite && wStrb_q[0] && awAddr_q[7:2] == cmp_ctrl_pkg::CTRL_OFFSET[7:2] |=> ctrl_q == $past(wData_q[5:0]))
    else $error("mode write lost");
  flag_cov_c: cover property (@(posedge core_clk) disable iff (reset) $rose(changeFlag_q));
  irq_cov_c: cover property (@(posedge core_clk) disable iff (reset) $rose(irq));
  ref_cov_c: cover property (@(posedge core_clk) disable iff (reset) refSelect && ctrl_q[cmp_ctrl_pkg::INSWITCH_BIT]);
endmodule

// ### testbench/analog_pins_model.sv
// model: analog levels on port a pins 0 to 3 seen as comparator outcomes
`timescale 1ns/1ps
module analog_pins_model (
  // clock
  input wire logic core_clk,
  // wanted levels and response speed
  input wire logic [3:0] refSet,
  input wire logic [3:0] pinSet,
  input wire logic slow,
  // comparator outcomes
  output logic [3:0] pinAboveRef,
  output logic [3:0] pinAbovePin
);
  logic [3:0] refMid_q;
  logic [3:0] pinMid_q;
  // outcomes follow the levels after one cycle, or two when slow
  always_ff @(posedge core_clk) begin
    refMid_q <= refSet;
    pinMid_q <= pinSet;
    pinAboveRef <= slow ? refMid_q : refSet;
    pinAbovePin <= slow ? pinMid_q : pinSet;
  end
endmodule

// ### testbench/dual_comparator_control_test.sv
// testbench: register, result, pin and change flag checks
`timescale 1ns/1ps
module dual_comparator_control_test;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, refSelect, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] pinAboveRef, pinAbovePin, refSet = 4'h5, pinSet = 4'h1;
  logic slow = 1'h0;
  logic [5:4] portADirection = 2'h3, portAPinOut, portAPinOe;
  logic [5:0] codes [9] = '{6'h30, 6'h01, 6'h12, 6'h23, 6'h34, 6'h3d, 6'h06, 6'h1e, 6'h37};
  int miscompares = 0, checks = 0;
  dual_comparator_control u_dual_comparator_control (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pinAboveRef, .pinAbovePin, .portADirection, .portAPinOut, .portAPinOe, .refSelect, .irq);
  analog_pins_model u_analog_pins_model (.core_clk, .refSet, .pinSet, .slow, .pinAboveRef, .pinAbovePin);
  // clock
  always #5 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bus write, held until each channel is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  // bus read
  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // wait out input, result and flag latency
  task automatic settle;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  // expected control read: results from the mode's pairing, then inverts
  function automatic logic [31:0] expCtrl(input logic [5:0] c, input logic [3:0] r, input logic [3:0] p);
    logic a, b;
    a = c[3] ? r[3] : r[0];
    b = c[3] ? r[2] : r[1];
    if (c[2:0] != cmp_ctrl_pkg::MODE_REF) begin
      a = p[0];
      b = p[1];
    end
    if (c[2:0] == 3'h0 || c[2:0] == cmp_ctrl_pkg::MODE_OFF) return {26'h0, c};
    return {24'h0, b ^ c[5], a ^ c[4], c};
  endfunction
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
  // tests
  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    axr(cmp_ctrl_pkg::CTRL_OFFSET);
    chk("control reset", 32'h07, rd);
    axr(cmp_ctrl_pkg::IRQ_MASK_OFFSET);
    chk("mask reset", 32'h0, rd);
    axr(8'hb0);
    chk("unmapped read", {cmp_ctrl_pkg::RESP_SLVERR, 30'h0}, {rs, rd[29:0]});
    axw(8'hb0, 32'h1);
    chk("unmapped write", {30'h0, cmp_ctrl_pkg::RESP_SLVERR}, {30'h0, rs});
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      axw(cmp_ctrl_pkg::CTRL_OFFSET, {24'h0, 2'h3, codes[i]});
      chk("write response", {30'h0, cmp_ctrl_pkg::RESP_OKAY}, {30'h0, rs});
      settle();
      axr(cmp_ctrl_pkg::CTRL_OFFSET);
      chk("control", expCtrl(codes[i], refSet, pinSet), rd);
      chk("read response", {30'h0, cmp_ctrl_pkg::RESP_OKAY}, {30'h0, rs});
      chk("refSelect", {31'h0, codes[i][2:0] == cmp_ctrl_pkg::MODE_REF}, {31'h0, refSelect});
    end
    $display("test modes done");
    axw(cmp_ctrl_pkg::CTRL_OFFSET, {29'h0, cmp_ctrl_pkg::MODE_OUT});
    portADirection <= 2'h0;
    settle();
    chk("pin enable", 32'h3, {30'h0, portAPinOe});
    chk("pin out", 32'h1, {30'h0, portAPinOut});
    @(posedge core_clk);
    portADirection <= 2'h3;
    settle();
    chk("pin enable off", 32'h0, {30'h0, portAPinOe});
    $display("test pins done");
    axw(cmp_ctrl_pkg::IRQ_MASK_OFFSET, 32'h0);
    axw(cmp_ctrl_pkg::CTRL_OFFSET, 32'h01);
    // clear the flag left over from the mode sweep so the next set is really caused by the input change
    axr(cmp_ctrl_pkg::CTRL_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    chk("flag idle", 32'h0, rd);
    slow <= 1'h1;
    pinSet <= 4'h0;
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    axr(cmp_ctrl_pkg::CTRL_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    chk("flag masked", 32'h1, rd);
    axw(cmp_ctrl_pkg::IRQ_MASK_OFFSET, 32'h1);
    pinSet <= 4'h1;
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    chk("flag kept", 32'h1, rd);
    axr(cmp_ctrl_pkg::CTRL_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    axr(cmp_ctrl_pkg::IRQ_STATUS_OFFSET);
    #1;
    chk("flag cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge core_clk);
    reset <= 1'h1;
    repeat (2) @(posedge core_clk);
    reset <= 1'h0;
    axr(cmp_ctrl_pkg::CTRL_OFFSET);
    chk("control reset again", 32'h07, rd);
    $display("test flag done");
    finish_test();
  end
endmodule
